// >>> design/rtcpc_consts.svh
// constants of the rtc pin control block: offsets, fields, reset values, timing
// assumes a 100 MHz sys_clk; included by bare name from every design file
`ifndef RTCPC_CONSTS_SVH
`define RTCPC_CONSTS_SVH

// ==================================================================
// register map
`define RTCPC_CTRL_OFS      8'h0e
`define RTCPC_FLAG_OFS      8'h0f
`define RTCPC_CTRL_RST      8'h1c
`define RTCPC_FLAG_RST      8'h00

// ==================================================================
// control register fields
`define RTCPC_ALM1_EN_BIT   0
`define RTCPC_ALM2_EN_BIT   1
`define RTCPC_IRQ_SEL_BIT   2
`define RTCPC_RATE_LO_BIT   3
`define RTCPC_RATE_HI_BIT   4
`define RTCPC_OSC_DIS_BIT   7

// ==================================================================
// flag register fields
`define RTCPC_ALM1_FLAG_BIT 0
`define RTCPC_ALM2_FLAG_BIT 1
`define RTCPC_EN32_BIT      3

// ==================================================================
// widths
`define RTCPC_MEM_AW        13
`define RTCPC_TMR_W         25
`define RTCPC_DIV_W         16

// ==================================================================
// timing, clock period in ns and times in ms
`define RTCPC_CLK_NS        10
`define RTCPC_REC_MS        2
`define RTCPC_BUTTON_DEBOUNCE_INTERVAL_MS       250
`define RTCPC_RSTACT_MS     250
`define RTCPC_REC_CYC       ((`RTCPC_REC_MS * 1000000) / `RTCPC_CLK_NS)
`define RTCPC_BUTTON_DEBOUNCE_INTERVAL_CYC      ((`RTCPC_BUTTON_DEBOUNCE_INTERVAL_MS * 1000000) / `RTCPC_CLK_NS)
`define RTCPC_RSTACT_CYC    ((`RTCPC_RSTACT_MS * 1000000) / `RTCPC_CLK_NS)

`endif

// >>> design/rtcpc_pkg.sv
// types of the rtc pin control block
// assumes rtcpc_consts.svh for widths
`include "rtcpc_consts.svh"

package rtcpc_pkg;

	// ==================================================================
	// reset pin sequencer states, one-hot
	typedef enum logic [5:0] {
		RP_PFAIL   = 6'h01,
		RP_RECOV   = 6'h02,
		RP_HOLD    = 6'h04,
		RP_IDLE    = 6'h08,
		RP_DEBNC   = 6'h10,
		RP_WAITREL = 6'h20
	} rtcpc_rst_e;

	// ==================================================================
	// state of the top module, apart from the interval timer count held in rtcpc_tmr_s
	typedef struct packed {
		logic [7:0]                ctrl;
		logic [1:0]                flags;
		logic                      en32;
		logic [`RTCPC_DIV_W-1:0]   divCnt;
		rtcpc_rst_e                rstSt;
		logic                      pinPrev;
		logic                      rstOeN;
		logic                      irqOeN;
		logic                      clkOeN;
		logic                      memWrEn;
		logic [`RTCPC_MEM_AW-1:0]  memAddr;
		logic [7:0]                memData;
		logic [7:0]                rdData;
	} rtcpc_state_s;

	// ==================================================================
	// state of the interval timer
	typedef struct packed {
		logic [`RTCPC_TMR_W-1:0]   cnt;
	} rtcpc_tmr_s;

endpackage : rtcpc_pkg

// >>> design/rtcpc_timer.sv
// down-counting interval timer for the reset pin sequencer
// assumes the loader holds its state until expired is seen
`timescale 1ns/1ps
`default_nettype none
`include "rtcpc_consts.svh"

module rtcpc_timer (
	input  wire logic                     sys_clk,  // system clock
	input  wire logic                     reset,    // synchronous reset
	input  wire logic                     ce,       // clock enable
	input  wire logic                     load,     // start a new interval
	input  wire logic [`RTCPC_TMR_W-1:0]  loadVal,  // cycles to count
	output      logic                     expired   // count reached zero
);

	rtcpc_pkg::rtcpc_tmr_s st_ff;
	rtcpc_pkg::rtcpc_tmr_s nxt_st;

	// load or count down, holding at zero
	always_comb begin
		nxt_st = st_ff;
		if (ce) begin
			if (load) begin
				nxt_st.cnt = loadVal;
			end else if (st_ff.cnt != '0) begin
				nxt_st.cnt = st_ff.cnt - `RTCPC_TMR_W'(1);
			end
		end
	end

	// register the state
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign expired = (st_ff.cnt == '0);

endmodule : rtcpc_timer
`default_nettype wire

// >>> design/rtcpc_pin_ctrl.sv
// pin control of an rtc: write protect gate, interrupt or square-wave output,
// reset pin with power fail and pushbutton, 32 kHz output
// assumes all inputs synchronous to sys_clk; oscTick is a one-cycle pulse at 65.536 kHz
`timescale 1ns/1ps
`default_nettype none
`include "rtcpc_consts.svh"

module rtcpc_pin_ctrl #(
	parameter int unsigned REC_CYC    = `RTCPC_REC_CYC,    // recovery time in cycles
	parameter int unsigned BUTTON_DEBOUNCE_INTERVAL_CYC   = `RTCPC_BUTTON_DEBOUNCE_INTERVAL_CYC,   // debounce time in cycles
	parameter int unsigned RSTACT_CYC = `RTCPC_RSTACT_CYC  // reset-active time in cycles
) (
	input  wire logic                      sys_clk,      // system clock, 100 MHz
	input  wire logic                      reset,        // synchronous reset, active high
	input  wire logic                      ce,           // clock enable, freezes state when low
	input  wire logic                      regWrEn,      // register write strobe
	input  wire logic                      regRdEn,      // register read strobe
	input  wire logic [7:0]                regAddr,      // register address
	input  wire logic [7:0]                regWrData,    // register write data
	output      logic [7:0]                regRdData,    // register read data
	input  wire logic                      wpIn,         // write protect pin level
	input  wire logic                      wpDriven,     // write protect pin is driven
	input  wire logic                      memWrReq,     // memory write request
	input  wire logic [`RTCPC_MEM_AW-1:0]  memWrAddrIn,  // memory write address
	input  wire logic [7:0]                memWrDataIn,  // memory write data
	output      logic                      memWrEn,      // memory write accepted
	output      logic [`RTCPC_MEM_AW-1:0]  memWrAddr,    // accepted address
	output      logic [7:0]                memWrData,    // accepted data
	input  wire logic                      alarm1Match,  // alarm 1 match pulse
	input  wire logic                      alarm2Match,  // alarm 2 match pulse
	input  wire logic                      oscTick,      // oscillator tick pulse
	input  wire logic                      oscRunning,   // oscillator is running
	input  wire logic                      vccOk,        // supply above power_fail_threshold
	output      logic                      irqWaveOut,   // irq_or_wave_out_n data, always low
	output      logic                      irqWaveOeN,   // irq_or_wave_out_n pulls low when 0
	output      logic                      clk32Out,     // 32 kHz pin data, always low
	output      logic                      clk32OeN,     // 32 kHz pin pulls low when 0
	input  wire logic                      rstPinIn,     // reset pin level
	output      logic                      rstPinOut,    // reset pin data, always low
	output      logic                      rstPinOeN     // reset pin pulls low when 0
);

	// ==================================================================
	// state and reset value
	localparam rtcpc_pkg::rtcpc_state_s ST_RST = '{
		ctrl:    `RTCPC_CTRL_RST,
		flags:   2'h0,
		en32:    1'b0,
		divCnt:  '0,
		rstSt:   rtcpc_pkg::RP_PFAIL,
		pinPrev: 1'b0,
		rstOeN:  1'b0,
		irqOeN:  1'b1,
		clkOeN:  1'b1,
		memWrEn: 1'b0,
		memAddr: '0,
		memData: 8'h00,
		rdData:  8'h00
	};

	rtcpc_pkg::rtcpc_state_s  st_ff;
	rtcpc_pkg::rtcpc_state_s  nxt_st;
	logic                     tmrLoad;
	logic [`RTCPC_TMR_W-1:0]  tmrVal;
	logic                     tmrExpired;
	logic                     protect;
	logic                     waveSel;
	logic                     irqActive;
	logic                     drive;
	logic                     wrCtrl;
	logic                     wrFlag;
	logic [1:0]               flagKeep;
	logic [1:0]               flagSet;

	// ==================================================================
	// interval timer shared by the recovery, hold and debounce phases of the reset pin
	rtcpc_timer u_timer (
		.sys_clk (sys_clk),
		.reset   (reset),
		.ce      (ce),
		.load    (tmrLoad),
		.loadVal (tmrVal),
		.expired (tmrExpired)
	);

	// undriven pin reads as low through the pulldown
	assign protect = wpIn & wpDriven;

	// square-wave rate select from the divider
	always_comb begin
		case ({st_ff.ctrl[`RTCPC_RATE_HI_BIT], st_ff.ctrl[`RTCPC_RATE_LO_BIT]})
			2'h0:    waveSel = st_ff.divCnt[15];
			2'h1:    waveSel = st_ff.divCnt[3];
			2'h2:    waveSel = st_ff.divCnt[2];
			default: waveSel = st_ff.divCnt[0];
		endcase
	end

	// alarm interrupt is a flag that is enabled
	assign irqActive = |(st_ff.flags & st_ff.ctrl[`RTCPC_ALM2_EN_BIT:`RTCPC_ALM1_EN_BIT]);

	// register decode
	assign wrCtrl = regWrEn && (regAddr == `RTCPC_CTRL_OFS);
	assign wrFlag = regWrEn && (regAddr == `RTCPC_FLAG_OFS);
	assign flagKeep = wrFlag ? regWrData[`RTCPC_ALM2_FLAG_BIT:`RTCPC_ALM1_FLAG_BIT] : 2'h3;
	assign flagSet = {alarm2Match, alarm1Match};

	// ==================================================================
	// next state
	always_comb begin
		nxt_st = st_ff;
		tmrLoad = 1'b0;
		tmrVal = '0;
		drive = 1'b0;
		if (ce) begin
			// registers
			if (wrCtrl) begin
				nxt_st.ctrl = regWrData;
			end
			if (wrFlag) begin
				nxt_st.en32 = regWrData[`RTCPC_EN32_BIT];
			end
			// set wins over a clearing write
			nxt_st.flags = (st_ff.flags & flagKeep) | flagSet;
			if (regRdEn) begin
				case (regAddr)
					`RTCPC_CTRL_OFS: nxt_st.rdData = st_ff.ctrl;
					`RTCPC_FLAG_OFS: nxt_st.rdData = {4'h0, st_ff.en32, 1'b0, st_ff.flags};
					default:         nxt_st.rdData = 8'h00;
				endcase
			end

			// memory write gate
			nxt_st.memWrEn = memWrReq && !protect;
			nxt_st.memAddr = memWrAddrIn;
			nxt_st.memData = memWrDataIn;

			// divider runs from the tick whatever the supply
			if (oscTick) begin
				nxt_st.divCnt = st_ff.divCnt + `RTCPC_DIV_W'(1);
			end
			nxt_st.clkOeN = ~(st_ff.en32 & ~st_ff.divCnt[0]);

			// multifunction output
			if (st_ff.ctrl[`RTCPC_IRQ_SEL_BIT]) begin
				nxt_st.irqOeN = ~irqActive;
			end else begin
				nxt_st.irqOeN = waveSel;
			end

			// reset pin sequencer
			nxt_st.pinPrev = rstPinIn;
			case (st_ff.rstSt)
				rtcpc_pkg::RP_PFAIL: begin
					drive = 1'b1;
					if (vccOk) begin
						if (st_ff.ctrl[`RTCPC_OSC_DIS_BIT] || !oscRunning) begin
							nxt_st.rstSt = rtcpc_pkg::RP_IDLE;
							drive = 1'b0;
						end else begin
							nxt_st.rstSt = rtcpc_pkg::RP_RECOV;
							tmrLoad = 1'b1;
							tmrVal = `RTCPC_TMR_W'(REC_CYC - 1);
						end
					end
				end
				rtcpc_pkg::RP_RECOV: begin
					drive = 1'b1;
					if (tmrExpired) begin
						nxt_st.rstSt = rtcpc_pkg::RP_HOLD;
						tmrLoad = 1'b1;
						tmrVal = `RTCPC_TMR_W'(RSTACT_CYC - 1);
					end
				end
				rtcpc_pkg::RP_HOLD: begin
					drive = 1'b1;
					if (tmrExpired) begin
						nxt_st.rstSt = rtcpc_pkg::RP_IDLE;
						drive = 1'b0;
					end
				end
				rtcpc_pkg::RP_IDLE: begin
					if (st_ff.pinPrev && !rstPinIn) begin
						nxt_st.rstSt = rtcpc_pkg::RP_DEBNC;
						tmrLoad = 1'b1;
						tmrVal = `RTCPC_TMR_W'(BUTTON_DEBOUNCE_INTERVAL_CYC - 1);
						drive = 1'b1;
					end
				end
				rtcpc_pkg::RP_DEBNC: begin
					drive = 1'b1;
					if (tmrExpired) begin
						nxt_st.rstSt = rtcpc_pkg::RP_WAITREL;
						drive = 1'b0;
					end
				end
				rtcpc_pkg::RP_WAITREL: begin
					if (rstPinIn) begin
						nxt_st.rstSt = rtcpc_pkg::RP_HOLD;
						tmrLoad = 1'b1;
						tmrVal = `RTCPC_TMR_W'(RSTACT_CYC - 1);
						drive = 1'b1;
					end
				end
				default: begin
					nxt_st.rstSt = rtcpc_pkg::RP_PFAIL;
					drive = 1'b1;
				end
			endcase
			// supply loss overrides any phase
			if (!vccOk) begin
				nxt_st.rstSt = rtcpc_pkg::RP_PFAIL;
				tmrLoad = 1'b0;
				drive = 1'b1;
			end
			nxt_st.rstOeN = ~drive;
		end
	end

	// register the state
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			st_ff <= ST_RST;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ==================================================================
	// outputs, memory path untouched by reset pin level
	assign regRdData  = st_ff.rdData;
	assign memWrEn    = st_ff.memWrEn;
	assign memWrAddr  = st_ff.memAddr;
	assign memWrData  = st_ff.memData;
	assign irqWaveOut = 1'b0;
	assign irqWaveOeN = st_ff.irqOeN;
	assign clk32Out   = 1'b0;
	assign clk32OeN   = st_ff.clkOeN;
	assign rstPinOut  = 1'b0;
	assign rstPinOeN  = st_ff.rstOeN;

	// ==================================================================
	// checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	sequence s_pbEnter;
		ce && st_ff.rstSt == rtcpc_pkg::RP_IDLE && st_ff.pinPrev && !rstPinIn && vccOk;
	endsequence
	sequence s_pbDrive;
		st_ff.rstSt == rtcpc_pkg::RP_DEBNC && !rstPinOeN;
	endsequence
	sequence s_bypass;
		ce && st_ff.rstSt == rtcpc_pkg::RP_PFAIL && vccOk && st_ff.ctrl[`RTCPC_OSC_DIS_BIT];
	endsequence

	property p_wpBlock;
		ce && memWrReq && wpIn && wpDriven |=> !memWrEn;
	endproperty
	a_wpBlock: assert property (p_wpBlock) else $error("write passed while protected");

	property p_wpPass;
		ce && memWrReq && !wpIn |=> memWrEn && memWrAddr == $past(memWrAddrIn);
	endproperty
	a_wpPass: assert property (p_wpPass) else $error("write refused while unprotected");

	property p_wpFloat;
		ce && memWrReq && !wpDriven |=> memWrEn;
	endproperty
	a_wpFloat: assert property (p_wpFloat) else $error("undriven protect blocked a write");

	property p_irqIdle;
		ce && st_ff.ctrl[`RTCPC_IRQ_SEL_BIT] && !irqActive |=> irqWaveOeN;
	endproperty
	a_irqIdle: assert property (p_irqIdle) else $error("interrupt pin low without alarm");

	property p_wave;
		ce && !st_ff.ctrl[`RTCPC_IRQ_SEL_BIT] |=> irqWaveOeN == $past(waveSel);
	endproperty
	a_wave: assert property (p_wave) else $error("square wave not on output");

	property p_irqHold;
		ce && st_ff.ctrl[`RTCPC_IRQ_SEL_BIT] && irqActive && !wrFlag && !wrCtrl
			|=> !irqWaveOeN && irqActive;
	endproperty
	a_irqHold: assert property (p_irqHold) else $error("alarm interrupt dropped");

	property p_por;
		@(posedge sys_clk) disable iff (1'b0)
		reset |=> st_ff.ctrl == `RTCPC_CTRL_RST && irqWaveOeN && !rstPinOeN;
	endproperty
	a_por: assert property (p_por) else $error("bad power-up state");

	property p_pfail;
		ce && !vccOk |=> !rstPinOeN && st_ff.rstSt == rtcpc_pkg::RP_PFAIL;
	endproperty
	a_pfail: assert property (p_pfail) else $error("reset pin not low on supply loss");

	property p_bypass;
		s_bypass |=> rstPinOeN && st_ff.rstSt == rtcpc_pkg::RP_IDLE;
	endproperty
	a_bypass: assert property (p_bypass) else $error("recovery not bypassed");

	property p_pbStart;
		s_pbEnter |=> s_pbDrive;
	endproperty
	a_pbStart: assert property (p_pbStart) else $error("pushbutton not debounced");

	property p_recov;
		ce && st_ff.rstSt == rtcpc_pkg::RP_PFAIL && vccOk && oscRunning
			&& !st_ff.ctrl[`RTCPC_OSC_DIS_BIT] |=> !rstPinOeN [*2];
	endproperty
	a_recov: assert property (p_recov) else $error("reset released without recovery");

endmodule : rtcpc_pin_ctrl
`default_nettype wire

// >>> verification/rtcpc_host_model.sv
// far side of the pin control block: system reset net, pushbutton and pull-ups
// assumes the device drives each open-drain pin only through its low-active enable
`timescale 1ns/1ps
`default_nettype none

module rtcpc_host_model (
	input  wire logic  rstPinOeN,      // device pulls reset net low when 0
	input  wire logic  irqWaveOeN,     // device pulls irq/wave net low when 0
	input  wire logic  clk32OeN,       // device pulls 32 kHz net low when 0
	input  wire logic  buttonPressed,  // pushbutton shorts reset net to ground
	output      logic  rstPinIn,       // resolved reset net level
	output      logic  irqLine,        // resolved irq/wave net level
	output      logic  clk32Line       // resolved 32 kHz net level
);
	// ==================================================================
	// wired-and nets with pull-ups, any puller wins
	assign rstPinIn  = (rstPinOeN === 1'b0 || buttonPressed) ? 1'b0 : 1'b1;
	assign irqLine   = (irqWaveOeN === 1'b0) ? 1'b0 : 1'b1;
	assign clk32Line = (clk32OeN === 1'b0) ? 1'b0 : 1'b1;
endmodule : rtcpc_host_model

`default_nettype wire

// >>> verification/rtcpc_pin_ctrl_tb.sv
// self-checking bench of the rtc pin control block
// assumes rtcpc_host_model for the reset net and pull-ups, short interval parameters
`timescale 1ns/1ps
`default_nettype none
`include "rtcpc_consts.svh"
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin num_errors++; \
	$display("ERROR %s expected %h seen %h", nm, exp, got); end end

module rtcpc_pin_ctrl_tb;
	localparam int unsigned REC = 20;
	localparam int unsigned BUTTON_DEBOUNCE_INTERVAL = 30;
	localparam int unsigned RACT = 25;
	logic sys_clk, reset, regWrEn, regRdEn, wpIn, wpDriven, memWrReq, memWrEn;
	logic alarm1Match, alarm2Match, oscRunning, vccOk, irqWaveOut, irqWaveOeN;
	logic clk32Out, clk32OeN, rstPinIn, rstPinOut, rstPinOeN, buttonPressed;
	logic irqLine, clk32Line, ce;
	logic [7:0] regAddr, regWrData, regRdData, memWrDataIn, memWrData;
	logic [12:0] memWrAddrIn, memWrAddr;
	int num_errors, check_count, n;
	logic [1:0] wpTab[4] = '{2'b11, 2'b01, 2'b10, 2'b00};
	int rateCnt[4] = '{0, 8, 16, 64};

	rtcpc_pin_ctrl #(.REC_CYC(REC), .BUTTON_DEBOUNCE_INTERVAL_CYC(BUTTON_DEBOUNCE_INTERVAL), .RSTACT_CYC(RACT)) u_dut (
		.sys_clk(sys_clk), .reset(reset), .ce(ce), .regWrEn(regWrEn), .regRdEn(regRdEn),
		.regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData), .wpIn(wpIn),
		.wpDriven(wpDriven), .memWrReq(memWrReq), .memWrAddrIn(memWrAddrIn),
		.memWrDataIn(memWrDataIn), .memWrEn(memWrEn), .memWrAddr(memWrAddr),
		.memWrData(memWrData), .alarm1Match(alarm1Match), .alarm2Match(alarm2Match),
		.oscTick(1'b1), .oscRunning(oscRunning), .vccOk(vccOk), .irqWaveOut(irqWaveOut),
		.irqWaveOeN(irqWaveOeN), .clk32Out(clk32Out), .clk32OeN(clk32OeN),
		.rstPinIn(rstPinIn), .rstPinOut(rstPinOut), .rstPinOeN(rstPinOeN));

	rtcpc_host_model u_host (.rstPinOeN(rstPinOeN), .irqWaveOeN(irqWaveOeN),
		.clk32OeN(clk32OeN), .buttonPressed(buttonPressed), .rstPinIn(rstPinIn),
		.irqLine(irqLine), .clk32Line(clk32Line));

	// ==================================================================
	// clock and watchdog
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	initial begin
		repeat (5000) @(posedge sys_clk);
		num_errors++;
		finish_test();
	end

	// ==================================================================
	// access tasks
	task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		regWrEn <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge sys_clk);
		regWrEn <= 1'b0;
	endtask : reg_write

	task automatic reg_read(input logic [7:0] a, input logic [7:0] exp, input string nm);
		@(posedge sys_clk);
		regRdEn <= 1'b1;
		regAddr <= a;
		@(posedge sys_clk);
		regRdEn <= 1'b0;
		#1 `CHK(nm, exp, regRdData)
	endtask : reg_read

	// waits for the reset enable to reach val, n counts the cycles taken
	task automatic wait_rst(input logic val, input int lim, output int cyc);
		cyc = 0;
		#1;
		while (rstPinOeN !== val && cyc < lim) begin
			@(posedge sys_clk);
			#1 cyc++;
		end
	endtask : wait_rst

	// counts level changes of a resolved net over 64 cycles
	task automatic count_edges(input bit pick32, output int cnt);
		logic prev, cur;
		cnt = 0;
		repeat (4) @(posedge sys_clk);
		#1 prev = pick32 ? clk32Line : irqLine;
		repeat (64) begin
			@(posedge sys_clk);
			#1 cur = pick32 ? clk32Line : irqLine;
			if (cur !== prev) cnt++;
			prev = cur;
		end
	endtask : count_edges

	task automatic pulse_alarm(input bit second);
		@(posedge sys_clk);
		if (second) alarm2Match <= 1'b1; else alarm1Match <= 1'b1;
		@(posedge sys_clk);
		alarm1Match <= 1'b0;
		alarm2Match <= 1'b0;
		repeat (2) @(posedge sys_clk);
		#1;
	endtask : pulse_alarm

	task automatic end_test(input string nm);
		$display("test %s done", nm);
	endtask : end_test

	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : finish_test

	// ==================================================================
	// test sequence
	initial begin
		{regWrEn, regRdEn, memWrReq, alarm1Match, alarm2Match, vccOk, buttonPressed} = '0;
		{regAddr, regWrData, memWrDataIn, memWrAddrIn, wpIn, wpDriven} = '0;
		reset = 1'b1;
		oscRunning = 1'b1;
		ce = 1'b1;
		num_errors = 0;
		check_count = 0;
		repeat (5) @(posedge sys_clk);
		reset <= 1'b0;
		reg_read(`RTCPC_CTRL_OFS, 8'h1c, "ctrl reset");
		reg_read(8'h10, 8'h00, "unmapped read");
		reg_read(`RTCPC_FLAG_OFS, 8'h00, "flags reset");
		`CHK("irq idle", 1'b1, irqWaveOeN)
		`CHK("rst low no supply", 1'b0, rstPinOeN)
		`CHK("open drain data", 3'h0, {irqWaveOut, clk32Out, rstPinOut})
		end_test("reset values");
		@(posedge sys_clk);
		vccOk <= 1'b1;
		wait_rst(1'b1, REC + RACT + 10, n);
		`CHK("rst release", 1'b1, rstPinOeN)
		`CHK("rst recovery length", 1'b1, n >= REC + RACT - 3)
		@(posedge sys_clk);
		vccOk <= 1'b0;
		wait_rst(1'b0, 2, n);
		`CHK("rst on fail", 1'b0, rstPinOeN)
		reg_write(`RTCPC_CTRL_OFS, 8'h9c);
		reg_read(`RTCPC_CTRL_OFS, 8'h9c, "ctrl while reset");
		@(posedge sys_clk);
		vccOk <= 1'b1;
		wait_rst(1'b1, 3, n);
		`CHK("osc disabled bypass", 1'b1, rstPinOeN)
		@(posedge sys_clk);
		vccOk <= 1'b0;
		oscRunning <= 1'b0;
		reg_write(`RTCPC_CTRL_OFS, 8'h1c);
		@(posedge sys_clk);
		vccOk <= 1'b1;
		wait_rst(1'b1, 3, n);
		`CHK("osc stopped bypass", 1'b1, rstPinOeN)
		oscRunning <= 1'b1;
		end_test("supply");
		repeat (3) @(posedge sys_clk);
		buttonPressed <= 1'b1;
		wait_rst(1'b0, 3, n);
		`CHK("button pull", 1'b0, rstPinOeN)
		wait_rst(1'b1, BUTTON_DEBOUNCE_INTERVAL + 5, n);
		`CHK("debounce end", 1'b1, rstPinOeN)
		`CHK("debounce length", 1'b1, n >= BUTTON_DEBOUNCE_INTERVAL - 3)
		repeat (10) @(posedge sys_clk);
		#1 `CHK("wait release", 1'b1, rstPinOeN)
		buttonPressed <= 1'b0;
		wait_rst(1'b0, 3, n);
		`CHK("hold after release", 1'b0, rstPinOeN)
		wait_rst(1'b1, RACT + 5, n);
		`CHK("hold end", 1'b1, rstPinOeN)
		`CHK("hold length", 1'b1, n >= RACT - 3)
		end_test("pushbutton");
		// a write made while the clock enable is low must be lost
		ce <= 1'b0;
		reg_write(`RTCPC_CTRL_OFS, 8'h00);
		ce <= 1'b1;
		reg_read(`RTCPC_CTRL_OFS, 8'h1c, "ctrl frozen");
		end_test("clock enable");
		for (int i = 0; i < 4; i++) begin
			@(posedge sys_clk);
			{wpIn, wpDriven} <= wpTab[i];
			memWrReq <= 1'b1;
			memWrAddrIn <= i[0] ? 13'h1fff : 13'h0000;
			memWrDataIn <= 8'h5a + 8'(i);
			@(posedge sys_clk);
			memWrReq <= 1'b0;
			#1 `CHK("mem write", !(wpTab[i][1] && wpTab[i][0]), memWrEn)
			if (memWrEn === 1'b1) `CHK("mem data", 8'h5a + 8'(i), memWrData)
			if (memWrEn === 1'b1) `CHK("mem addr", i[0] ? 13'h1fff : 13'h0000, memWrAddr)
		end
		end_test("write protect");
		reg_write(`RTCPC_CTRL_OFS, 8'h1d);
		pulse_alarm(1'b1);
		`CHK("disabled alarm", 1'b1, irqWaveOeN)
		reg_read(`RTCPC_FLAG_OFS, 8'h02, "alarm2 flag");
		pulse_alarm(1'b0);
		`CHK("alarm irq", 1'b0, irqWaveOeN)
		repeat (20) @(posedge sys_clk);
		#1 `CHK("alarm held", 1'b0, irqLine)
		reg_write(`RTCPC_FLAG_OFS, 8'h00);
		repeat (2) @(posedge sys_clk);
		#1 `CHK("alarm cleared", 1'b1, irqWaveOeN)
		end_test("alarm");
		for (int r = 0; r < 4; r++) begin
			reg_write(`RTCPC_CTRL_OFS, 8'(r << 3));
			count_edges(1'b0, n);
			`CHK("wave rate", rateCnt[r], n)
		end
		reg_write(`RTCPC_FLAG_OFS, 8'h08);
		count_edges(1'b1, n);
		`CHK("32k main", 64, n)
		@(posedge sys_clk);
		vccOk <= 1'b0;
		count_edges(1'b1, n);
		`CHK("32k backup", 64, n)
		reg_write(`RTCPC_FLAG_OFS, 8'h00);
		count_edges(1'b1, n);
		`CHK("32k off", 0, n)
		end_test("outputs");
		finish_test();
	end
endmodule : rtcpc_pin_ctrl_tb

`default_nettype wire
